// ---- strap_ctrl_pkg.sv ----
// constants of the processor strap and memory-subsystem control bank
// assumes an APB master on the core clock and straps steady around hard reset
// What this block does
// - bus mode field holds inverted straps during reset
// - mode 00 legacy, 10 split transaction
// - address-bus-driven flag from inverted first strap
// - processor index from inverted second strap
// - index reads 1 when strap asserted
// - queue depth code: 0->8, 1->16, n->n
// - bit 7 disables external interventions
// - bit 12 enables cache turnaround delay
// - count codes give 2 to 5 cycles
// - extended codes give 6 to 9 cycles
// - extension bit exists only on capable variant
// - five straps pick core ratio 2x-9.5x
// - strap codes decode to listed multipliers
// - bus at most 133 MHz, parity checked
// - split transaction flag set only in bus mode 10
// - version code in upper 16 bits
package strap_ctrl_pkg;
	localparam logic [11:0] MSC_OFS        = 12'h000;
	localparam logic [11:0] VER_OFS        = 12'h004;
	localparam logic [11:0] STAT_OFS       = 12'h008;

	localparam int          QD_LSB         = 3;
	localparam int          INTV_DIS_BIT   = 7;
	localparam int          TCEXT_BIT      = 10;
	localparam int          ADDR_DRV_BIT   = 11;
	localparam int          TCEN_BIT       = 12;
	localparam int          TC_LSB         = 13;
	localparam int          MODE_LSB       = 16;
	localparam int          INDEX_BIT      = 26;
	localparam int          VER_LSB        = 16;

	localparam int          ST_RATIO_LSB   = 0;
	localparam int          ST_RATIO_OK    = 6;
	localparam int          ST_SPLIT_OK    = 7;
	localparam int          ST_APAR_ERR    = 8;
	localparam int          ST_DPAR_ERR    = 9;
	localparam int          ST_STRAP_LSB   = 16;

	localparam logic [2:0]  QD_RST         = 3'h0;
	localparam logic [1:0]  TC_RST         = 2'h0;
	localparam logic [1:0]  MODE_LEGACY    = 2'h0;
	localparam logic [1:0]  MODE_SPLIT     = 2'h2;

	localparam logic [4:0]  QD_DEPTH_C0    = 5'h08;
	localparam logic [4:0]  QD_DEPTH_C1    = 5'h10;
	localparam logic [3:0]  TA_BASE        = 4'h2;
	localparam logic [3:0]  TA_EXT_BASE    = 4'h6;

	localparam int          BUS_MAX_MHZ    = 133;
	localparam int          RATIO_MIN_X2   = 4;
	localparam int          RATIO_MAX_X2   = 32;
endpackage

// ---- strap_ctrl.sv ----
// processor strap capture, memory-subsystem control and version bank on APB
// assumes straps and parity inputs synchronous to core_clk; rst_n async low
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ns
module strap_ctrl #(
	parameter logic [15:0] VERSION_CODE = 16'h5A5A, // arbitrary value
	parameter logic [15:0] REVISION     = 16'h0001, // arbitrary value
	parameter int          HAS_TC_EXT   = 1,
	parameter int          BUS_MHZ      = 133
) (
	input  wire  logic        core_clk,
	input  wire  logic        rst_n,
	input  wire  logic        psel,
	input  wire  logic        penable,
	input  wire  logic        pwrite,
	input  wire  logic [11:0] paddr,
	input  wire  logic [31:0] pwdata,
	output logic        [31:0] prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire  logic        hard_reset_n,
	input  wire  logic [1:0]  bus_protocol_strap,
	input  wire  logic [4:0]  pll_cfg_strap,
	input  wire  logic        bus_par_chk,
	input  wire  logic [31:0] bus_addr,
	input  wire  logic [3:0]  bus_addr_par,
	input  wire  logic [63:0] bus_data,
	input  wire  logic [7:0]  bus_data_par,
	output logic        [1:0] bus_mode,
	output logic               split_transaction_protocol,
	output logic               addr_bus_driven_flag,
	output logic               processor_index,
	output logic        [4:0] data_txn_queue_depth,
	output logic               intervention_disable,
	output logic               turnaround_enable,
	output logic        [3:0] turnaround_cycles,
	output logic        [5:0] core_ratio_x2,
	output logic               core_ratio_valid,
	output logic        [3:0] addr_par_gen,
	output logic        [7:0] data_par_gen,
	output logic        [1:0] par_err
);

	if (HAS_TC_EXT != 0 && HAS_TC_EXT != 1)
		$error("HAS_TC_EXT must be 0 or 1");
	if (BUS_MHZ > strap_ctrl_pkg::BUS_MAX_MHZ || BUS_MHZ < 1)
		$error("bus clock above its limit");

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        hr_prev;
		logic [1:0]  mode;
		logic [1:0]  strap_lvl;
		logic        addr_drv;
		logic        idx;
		logic [4:0]  pll;
		logic [2:0]  qd;
		logic        intv_dis;
		logic        tc_ext;
		logic        tc_en;
		logic [1:0]  tc;
		logic [4:0]  qd_depth;
		logic [3:0]  ta_cyc;
		logic [5:0]  ratio_x2;
		logic        ratio_ok;
		logic        split_ok;
		logic [1:0]  perr;
		logic [3:0]  apar;
		logic [7:0]  dpar;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	logic [3:0] apar_calc;
	logic [7:0] dpar_calc;

	////////////////////////////////////////////////////////////////////////
	// odd parity per byte lane

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_par
			if (gi < 4) begin : g_a
				assign apar_calc[gi] = ~^bus_addr[gi*8 +: 8];
			end
			assign dpar_calc[gi] = ~^bus_data[gi*8 +: 8];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// multiplier straps to twice the bus-to-core ratio

	function automatic logic [6:0] decode_pll(input logic [4:0] cfg);
		unique case (cfg)
			5'h08:   decode_pll = {1'b1, 6'h04};
			5'h10:   decode_pll = {1'b1, 6'h06};
			5'h14:   decode_pll = {1'b1, 6'h08};
			5'h16:   decode_pll = {1'b1, 6'h0A};
			5'h12:   decode_pll = {1'b1, 6'h0B};
			5'h1A:   decode_pll = {1'b1, 6'h0C};
			5'h0A:   decode_pll = {1'b1, 6'h0D};
			5'h04:   decode_pll = {1'b1, 6'h0E};
			5'h02:   decode_pll = {1'b1, 6'h0F};
			5'h18:   decode_pll = {1'b1, 6'h10};
			5'h0C:   decode_pll = {1'b1, 6'h11};
			5'h0F:   decode_pll = {1'b1, 6'h12};
			5'h0E:   decode_pll = {1'b1, 6'h13};
			default: decode_pll = {1'b0, 6'h00};
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// next state

	logic        acc;
	logic        commit;
	logic        wr_msc;
	logic        wr_stat;
	logic        mapped;
	logic [31:0] rd_val;
	logic [6:0]  pll_dec;

	always_comb begin
		st_nxt = st_r;
		acc = psel && penable;
		commit = acc && st_r.pready;
		mapped = (paddr == strap_ctrl_pkg::MSC_OFS) || (paddr == strap_ctrl_pkg::VER_OFS) ||
			(paddr == strap_ctrl_pkg::STAT_OFS);
		wr_msc = commit && pwrite && (paddr == strap_ctrl_pkg::MSC_OFS);
		wr_stat = commit && pwrite && (paddr == strap_ctrl_pkg::STAT_OFS);
		rd_val = 32'h0000_0000;

		// straps: levels watched during hard reset, modes fixed at its release
		st_nxt.hr_prev = hard_reset_n;
		if (!hard_reset_n) begin
			st_nxt.mode = ~bus_protocol_strap;
			st_nxt.strap_lvl = bus_protocol_strap;
			st_nxt.pll = pll_cfg_strap;
		end
		if (hard_reset_n && !st_r.hr_prev) begin
			// straps are active low, so the asserted level reads as one
			st_nxt.addr_drv = ~bus_protocol_strap[0];
			st_nxt.idx = ~bus_protocol_strap[1];
		end

		// software fields; captured bits are not writable
		if (wr_msc) begin
			st_nxt.qd = pwdata[strap_ctrl_pkg::QD_LSB +: 3];
			st_nxt.intv_dis = pwdata[strap_ctrl_pkg::INTV_DIS_BIT];
			st_nxt.tc_ext = (HAS_TC_EXT == 1) ? pwdata[strap_ctrl_pkg::TCEXT_BIT] : 1'b0;
			st_nxt.tc_en = pwdata[strap_ctrl_pkg::TCEN_BIT];
			st_nxt.tc = pwdata[strap_ctrl_pkg::TC_LSB +: 2];
		end

		unique case (st_nxt.qd)
			3'h0:    st_nxt.qd_depth = strap_ctrl_pkg::QD_DEPTH_C0;
			3'h1:    st_nxt.qd_depth = strap_ctrl_pkg::QD_DEPTH_C1;
			default: st_nxt.qd_depth = {2'b00, st_nxt.qd};
		endcase
		if (!st_nxt.tc_en)
			st_nxt.ta_cyc = 4'h0;
		else if (st_nxt.tc_ext)
			st_nxt.ta_cyc = strap_ctrl_pkg::TA_EXT_BASE + {2'b00, st_nxt.tc};
		else
			st_nxt.ta_cyc = strap_ctrl_pkg::TA_BASE + {2'b00, st_nxt.tc};

		pll_dec = decode_pll(st_nxt.pll);
		st_nxt.ratio_ok = pll_dec[6];
		st_nxt.ratio_x2 = pll_dec[5:0];
		st_nxt.split_ok = (st_nxt.mode == strap_ctrl_pkg::MODE_SPLIT);

		// parity: generated every cycle, mismatches sticky; set beats clear
		st_nxt.apar = apar_calc;
		st_nxt.dpar = dpar_calc;
		if (wr_stat) begin
			if (pwdata[strap_ctrl_pkg::ST_APAR_ERR])
				st_nxt.perr[0] = 1'b0;
			if (pwdata[strap_ctrl_pkg::ST_DPAR_ERR])
				st_nxt.perr[1] = 1'b0;
		end
		if (bus_par_chk && (apar_calc != bus_addr_par))
			st_nxt.perr[0] = 1'b1;
		if (bus_par_chk && (dpar_calc != bus_data_par))
			st_nxt.perr[1] = 1'b1;

		// read mux; reserved bits, including 18-25 of the control register, read zero
		unique case (paddr)
			strap_ctrl_pkg::MSC_OFS: begin
				rd_val[strap_ctrl_pkg::QD_LSB +: 3] = st_r.qd;
				rd_val[strap_ctrl_pkg::INTV_DIS_BIT] = st_r.intv_dis;
				rd_val[strap_ctrl_pkg::TCEXT_BIT] = st_r.tc_ext;
				rd_val[strap_ctrl_pkg::ADDR_DRV_BIT] = st_r.addr_drv;
				rd_val[strap_ctrl_pkg::TCEN_BIT] = st_r.tc_en;
				rd_val[strap_ctrl_pkg::TC_LSB +: 2] = st_r.tc;
				rd_val[strap_ctrl_pkg::MODE_LSB +: 2] = st_r.mode;
				rd_val[strap_ctrl_pkg::INDEX_BIT] = st_r.idx;
			end
			strap_ctrl_pkg::VER_OFS: begin
				rd_val = {VERSION_CODE, REVISION};
			end
			strap_ctrl_pkg::STAT_OFS: begin
				rd_val[strap_ctrl_pkg::ST_RATIO_LSB +: 6] = st_r.ratio_x2;
				rd_val[strap_ctrl_pkg::ST_RATIO_OK] = st_r.ratio_ok;
				rd_val[strap_ctrl_pkg::ST_SPLIT_OK] = st_r.split_ok;
				rd_val[strap_ctrl_pkg::ST_APAR_ERR] = st_r.perr[0];
				rd_val[strap_ctrl_pkg::ST_DPAR_ERR] = st_r.perr[1];
				rd_val[strap_ctrl_pkg::ST_STRAP_LSB +: 5] = st_r.pll;
			end
			default: rd_val = 32'h0000_0000;
		endcase

		// one wait state: answer in the second access cycle
		st_nxt.pready = acc && !st_r.pready;
		if (acc && !st_r.pready) begin
			st_nxt.pslverr = !mapped;
			st_nxt.prdata = (pwrite || !mapped) ? 32'h0000_0000 : rd_val;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.hr_prev <= 1'b1;
			st_r.qd <= strap_ctrl_pkg::QD_RST;
			st_r.tc <= strap_ctrl_pkg::TC_RST;
			st_r.qd_depth <= strap_ctrl_pkg::QD_DEPTH_C0;
			st_r.mode <= strap_ctrl_pkg::MODE_LEGACY;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign bus_mode = st_r.mode;
	assign split_transaction_protocol = st_r.split_ok;
	assign addr_bus_driven_flag = st_r.addr_drv;
	assign processor_index = st_r.idx;
	assign data_txn_queue_depth = st_r.qd_depth;
	assign intervention_disable = st_r.intv_dis;
	assign turnaround_enable = st_r.tc_en;
	assign turnaround_cycles = st_r.ta_cyc;
	assign core_ratio_x2 = st_r.ratio_x2;
	assign core_ratio_valid = st_r.ratio_ok;
	assign addr_par_gen = st_r.apar;
	assign data_par_gen = st_r.dpar;
	assign par_err = st_r.perr;

	////////////////////////////////////////////////////////////////////////
	// checks

	// sampled rst_n keeps an attempt off the edge that releases reset
	AST_MODE_CAPT: assert property (@(posedge core_clk) disable iff (!rst_n)
		(rst_n && !hard_reset_n) |=> bus_mode == ~$past(bus_protocol_strap))
		else $error("bus mode not the inverted strap");

	AST_MODE_RO: assert property (@(posedge core_clk) disable iff (!rst_n)
		(hard_reset_n && wr_msc) |=> (bus_mode == $past(bus_mode) &&
			processor_index == $past(processor_index)))
		else $error("strap field changed by write");

	AST_DRV_INDEX: assert property (@(posedge core_clk) disable iff (!rst_n)
		(hard_reset_n && !st_r.hr_prev) |=> (addr_bus_driven_flag == ~$past(bus_protocol_strap[0])
			&& processor_index == ~$past(bus_protocol_strap[1])))
		else $error("flag or index not captured at release");

	AST_QDEPTH: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_msc |=> data_txn_queue_depth == (($past(pwdata[5:3]) == 3'h0) ? 5'h08 :
			($past(pwdata[5:3]) == 3'h1) ? 5'h10 : {2'b00, $past(pwdata[5:3])}))
		else $error("queue depth wrong");

	AST_INTV_DIS: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_msc |=> intervention_disable == $past(pwdata[7]) ##1
			intervention_disable == $past(intervention_disable, 1) || $past(wr_msc))
		else $error("intervention disable not taken");

	AST_TA: assert property (@(posedge core_clk) disable iff (!rst_n)
		(wr_msc && pwdata[12] && !pwdata[10]) |=> turnaround_cycles ==
			4'h2 + {2'b00, $past(pwdata[14:13])})
		else $error("turnaround count wrong");

	AST_TA_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
		!turnaround_enable |-> turnaround_cycles == 4'h0)
		else $error("turnaround active while disabled");

	AST_RATIO: assert property (@(posedge core_clk) disable iff (!rst_n)
		core_ratio_valid |-> (core_ratio_x2 >= 6'h04 && core_ratio_x2 <= 6'h20))
		else $error("ratio outside range");

	AST_VERSION: assert property (@(posedge core_clk) disable iff (!rst_n)
		(acc && !pready && !pwrite && paddr == strap_ctrl_pkg::VER_OFS) |=>
			(pready && prdata[31:16] == VERSION_CODE))
		else $error("version read wrong");

	AST_PERR: assert property (@(posedge core_clk) disable iff (!rst_n)
		(bus_par_chk && apar_calc != bus_addr_par) |=> par_err[0] ##1 par_err[0] ||
			$past(wr_stat))
		else $error("address parity error lost");

	AST_SPLIT: assert property (@(posedge core_clk) disable iff (!rst_n)
		split_transaction_protocol == (bus_mode == 2'h2))
		else $error("protocol flag disagrees with bus mode");

	AST_TA_EXT: assert property (@(posedge core_clk) disable iff (!rst_n)
		(HAS_TC_EXT == 1 && wr_msc && pwdata[12] && pwdata[10]) |=>
			turnaround_cycles == 4'h6 + {2'b00, $past(pwdata[14:13])})
		else $error("extended turnaround count wrong");

	AST_TA_EN: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_msc |=> turnaround_enable == $past(pwdata[12]))
		else $error("turnaround enable not taken");

	AST_DRV_RO: assert property (@(posedge core_clk) disable iff (!rst_n)
		(hard_reset_n && st_r.hr_prev && wr_msc) |=>
			addr_bus_driven_flag == $past(addr_bus_driven_flag))
		else $error("address-driven flag changed by write");

	AST_DPERR: assert property (@(posedge core_clk) disable iff (!rst_n)
		(bus_par_chk && dpar_calc != bus_data_par) |=> par_err[1])
		else $error("data parity error lost");

	AST_PAR_GEN: assert property (@(posedge core_clk) disable iff (!rst_n)
		rst_n |=> (addr_par_gen[3] == ~^$past(bus_addr[31:24]) &&
			data_par_gen[7] == ~^$past(bus_data[63:56])))
		else $error("generated parity not odd");

	AST_RATIO_LOW: assert property (@(posedge core_clk) disable iff (!rst_n)
		(rst_n && !hard_reset_n && pll_cfg_strap == 5'h08) |=>
			(core_ratio_valid && core_ratio_x2 == 6'h04))
		else $error("lowest multiplier code misread");

	AST_RATIO_HIGH: assert property (@(posedge core_clk) disable iff (!rst_n)
		(rst_n && !hard_reset_n && pll_cfg_strap == 5'h0E) |=>
			(core_ratio_valid && core_ratio_x2 == 6'h13))
		else $error("highest multiplier code misread");

	AST_RATIO_BAD: assert property (@(posedge core_clk) disable iff (!rst_n)
		(rst_n && !hard_reset_n && pll_cfg_strap == 5'h00) |=> !core_ratio_valid)
		else $error("unlisted multiplier code taken as valid");

endmodule

// ---- strap_bus_model.sv ----
// system-controller side: hard reset, bus-mode and multiplier straps, parity bus traffic
// assumes the bench asks for hard reset and bad parity through the request inputs
`timescale 1ns/1ns
module strap_bus_model (
	input  wire logic        core_clk,
	input  wire logic        hr_req,
	input  wire logic [1:0]  strap_set,
	input  wire logic [4:0]  pll_set,
	input  wire logic [1:0]  par_bad,
	output logic             hard_reset_n,
	output logic [1:0]       bus_protocol_strap,
	output logic [4:0]       pll_cfg_strap,
	output logic             bus_par_chk,
	output logic [31:0]      bus_addr,
	output logic [3:0]       bus_addr_par,
	output logic [63:0]      bus_data,
	output logic [7:0]       bus_data_par
);
	logic [31:0] lfsr;
	logic [63:0] dv;

	assign dv = {~lfsr, lfsr};

	// hard reset starts asserted so the first capture is never missed
	initial begin
		lfsr = 32'h0000ACE1;
		{hard_reset_n, bus_protocol_strap, pll_cfg_strap, bus_par_chk} = '0;
		{bus_addr, bus_addr_par, bus_data, bus_data_par} = '0;
	end

	// straps follow the request; the bench holds them steady across release
	always @(posedge core_clk) begin
		lfsr               <= lfsr * 32'h0019660D + 32'h3C6EF35F;
		hard_reset_n       <= ~hr_req;
		bus_protocol_strap <= strap_set;
		pll_cfg_strap      <= pll_set;
		bus_par_chk        <= 1'b1;
		bus_addr           <= lfsr;
		bus_data           <= dv;
		for (int b = 0; b < 8; b++) begin
			if (b < 4)
				bus_addr_par[b] <= ~^lfsr[8*b +: 8] ^ par_bad[0];
			bus_data_par[b] <= ~^dv[8*b +: 8] ^ (par_bad[1] & (b == 0));
		end
	end
endmodule

// ---- strap_ctrl_test.sv ----
// self-checking bench for the strap capture and memory-subsystem control bank
// assumes the system-controller model drives straps, hard reset and parity traffic
`timescale 1ns/1ns
module strap_ctrl_test;
	localparam logic [15:0] VER = 16'h3C3C; // arbitrary value
	localparam logic [15:0] REV = 16'h0007; // arbitrary value
	localparam logic [4:0]  PC [14] = '{5'h08, 5'h10, 5'h14, 5'h16, 5'h12, 5'h1A, 5'h0A,
		5'h04, 5'h02, 5'h18, 5'h0C, 5'h0F, 5'h0E, 5'h00};
	localparam logic [5:0]  PX [14] = '{6'h04, 6'h06, 6'h08, 6'h0A, 6'h0B, 6'h0C, 6'h0D,
		6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12, 6'h13, 6'h00};
	logic        core_clk = 1'b0, rst_n = 1'b0, hr_req = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, w;
	logic        pready, pslverr, err, hard_reset_n, bus_par_chk;
	logic [1:0]  strap_set = 2'h0, par_bad = 2'h0, s, bus_protocol_strap, bus_mode, par_err;
	logic [4:0]  pll_set = 5'h08, pll_cfg_strap, data_txn_queue_depth;
	logic        split_transaction_protocol, addr_bus_driven_flag, processor_index;
	logic        intervention_disable, turnaround_enable, core_ratio_valid;
	logic [3:0]  turnaround_cycles, bus_addr_par, addr_par_gen;
	logic [5:0]  core_ratio_x2;
	logic [31:0] bus_addr, pa;
	logic [63:0] bus_data, pd;
	logic [7:0]  bus_data_par, data_par_gen;
	integer      seed = 32'hC67F;
	int          error_cnt = 0, compares = 0;

	always #2 core_clk = ~core_clk;

	strap_ctrl #(.VERSION_CODE(VER), .REVISION(REV)) strap_ctrl_i (
		.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .hard_reset_n, .bus_protocol_strap, .pll_cfg_strap, .bus_par_chk,
		.bus_addr, .bus_addr_par, .bus_data, .bus_data_par, .bus_mode,
		.split_transaction_protocol, .addr_bus_driven_flag, .processor_index,
		.data_txn_queue_depth, .intervention_disable, .turnaround_enable, .turnaround_cycles,
		.core_ratio_x2, .core_ratio_valid, .addr_par_gen, .data_par_gen, .par_err);

	strap_bus_model strap_bus_model_i (
		.core_clk, .hr_req, .strap_set, .pll_set, .par_bad, .hard_reset_n,
		.bus_protocol_strap, .pll_cfg_strap, .bus_par_chk, .bus_addr, .bus_addr_par,
		.bus_data, .bus_data_par);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [4:0] depth(input logic [2:0] c);
		return (c == 3'h0) ? 5'h08 : (c == 3'h1) ? 5'h10 : {2'h0, c};
	endfunction

	function automatic logic [3:0] tcyc(input logic en, input logic ext, input logic [1:0] tc);
		return !en ? 4'h0 : ((ext ? 4'h6 : 4'h2) + {2'h0, tc});
	endfunction

	// odd parity per byte lane
	function automatic logic [7:0] oddp(input logic [63:0] v);
		for (int i = 0; i < 8; i++)
			oddp[i] = ~^v[8*i +: 8];
	endfunction

	// strap-captured bits as they must read back
	function automatic logic [31:0] ro(input logic [1:0] st);
		ro = 32'h0;
		ro[26] = ~st[1];
		ro[17:16] = ~st;
		ro[11] = ~st[0];
	endfunction

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// no fixed latency assumed: the answer is taken at the rising edge showing pready
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge core_clk);
	endtask

	task automatic finish_test();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		error_cnt++;
		$display("[FAIL] %0t watchdog expired", $time);
		finish_test();
	end

	initial begin
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		cmp(data_txn_queue_depth, 5'h08, "depth after reset");
		// every multiplier code plus one outside the table, all strap patterns
		for (int k = 0; k < 14; k++) begin
			s = k[1:0];
			@(posedge core_clk);
			hr_req <= 1'b1;
			strap_set <= s;
			pll_set <= PC[k];
			repeat (4) @(posedge core_clk);
			hr_req <= 1'b0;
			repeat (4) @(negedge core_clk);
			cmp(bus_mode, 2'(~s), "bus mode");
			cmp(split_transaction_protocol, (~s == 2'b10), "split mode");
			cmp(addr_bus_driven_flag, !s[0], "address-driven flag");
			cmp(processor_index, !s[1], "index");
			cmp(core_ratio_valid, (k < 13), "ratio valid");
			if (k < 13)
				cmp(core_ratio_x2, PX[k], "ratio");
			apb(1'b0, strap_ctrl_pkg::MSC_OFS, 32'h0);
			cmp(rd, ro(s), "msc strap bits");
		end
		// reserved 18-25 stay clear; read-only bits get random junk
		for (int i = 0; i < 64; i++) begin
			w = $random(seed) & 32'h04030880;
			w[5:3] = i[5:3];
			w[12] = i[0];
			w[10] = i[1];
			w[14:13] = i[3:2];
			apb(1'b1, strap_ctrl_pkg::MSC_OFS, w);
			cmp(err, 1'b0, "msc write err");
			apb(1'b0, strap_ctrl_pkg::MSC_OFS, 32'h0);
			cmp(rd, (w & 32'h000074B8) | ro(s), "msc readback");
			cmp(data_txn_queue_depth, depth(w[5:3]), "depth");
			cmp(intervention_disable, w[7], "intervention");
			cmp(turnaround_enable, w[12], "turnaround en");
			cmp(turnaround_cycles, tcyc(w[12], w[10], w[14:13]), "turnaround");
		end
		apb(1'b1, strap_ctrl_pkg::VER_OFS, 32'hFFFFFFFF);
		cmp(err, 1'b0, "version write err");
		apb(1'b0, strap_ctrl_pkg::VER_OFS, 32'h0);
		cmp(rd, {VER, REV}, "version");
		apb(1'b1, 12'hFFC, 32'hFFFFFFFF);
		cmp(err, 1'b1, "unmapped write");
		apb(1'b0, 12'h00C, 32'h0);
		cmp({err, rd}, {1'b1, 32'h0}, "unmapped read");
		cmp(par_err, 2'h0, "no parity error");
		// generated parity shows one edge after the bus value is taken
		@(negedge core_clk);
		pa = bus_addr;
		pd = bus_data;
		@(negedge core_clk);
		cmp(addr_par_gen, 4'(oddp({32'h0, pa})), "address parity out");
		cmp(data_par_gen, oddp(pd), "data parity out");
		for (int b = 1; b < 3; b++) begin
			@(posedge core_clk);
			par_bad <= b[1:0];
			@(posedge core_clk);
			par_bad <= 2'h0;
			repeat (3) @(negedge core_clk);
			cmp(par_err, b, "parity flag");
			apb(1'b0, strap_ctrl_pkg::STAT_OFS, 32'h0);
			cmp(rd[9:8], b, "parity status");
			apb(1'b1, strap_ctrl_pkg::STAT_OFS, 32'h00000300);
			cmp(par_err, 2'h0, "parity cleared");
		end
		finish_test();
	end
endmodule
